/* inc/abu_consts.svh */
`ifndef ABU_CONSTS_SVH
`define ABU_CONSTS_SVH

// Register byte offsets on the APB
`define ABU_OFS_CTRL       12'h000
`define ABU_OFS_ADDR_HIGH  12'h004
`define ABU_OFS_ADDR_LOW   12'h008
`define ABU_OFS_WAIT_STAT  12'h00C
`define ABU_OFS_FLAG_CLR   12'h010
`define ABU_OFS_INT_STAT   12'h014
`define ABU_OFS_INT_MASK   12'h018

// Field positions
`define ABU_BIT_ENABLE     7
`define ABU_BIT_ACTIVE     6
`define ABU_BIT_WAIT_EXIT  1
`define ABU_BIT_CLR_ENABLE 7
`define ABU_EV_TAKEN       0
`define ABU_EV_ENDED       1
`define ABU_EV_WAIT_EXIT   2
`define ABU_NUM_EV         3

// Reset values
`define ABU_RST_BYTE       8'h00
`define ABU_RST_ADDR       16'h0000
`define ABU_RST_EV         3'h0

// Forced opcode and vectors
`define ABU_SWI_OPCODE     8'h83
`define ABU_VEC_NORMAL     16'hFFFC
`define ABU_VEC_MONITOR    16'hFEFC

// APB answer latency in wait states
`define ABU_APB_WAIT       1

`endif

/* inc/abu_pkg.sv */
package abu_pkg;

    typedef enum logic [1:0] {
        ABU_IDLE = 2'b00,
        ABU_PEND = 2'b01,
        ABU_BRK  = 2'b11
    } abu_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        valid;
        logic        from_cpu;
        logic        opcode_fetch;
    } abu_cpu_bus_t;

    typedef struct packed {
        logic opcode;
        logic operand;
    } abu_hit_t;

endpackage

/* rtl/abu_addr_match.sv */
module abu_addr_match
    import abu_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input  wire logic              enable_i,
    input  wire logic              armed_i,
    input  wire logic              idle_i,
    input  wire logic [ADDR_W-1:0] breakpoint_request_addr_i,
    input  wire abu_cpu_bus_t      bus_i,
    output abu_hit_t               hit_o
);

    logic qualified;
    logic equal;

    // Only CPU program addresses count, never other bus masters
    assign qualified = bus_i.valid & bus_i.from_cpu; // [RULE_18]
    assign equal     = (bus_i.addr == breakpoint_request_addr_i);

    // Address bus frozen in wait/stop, so no match can arise there
    always_comb begin // [RULE_16]
        hit_o.opcode  = 1'b0;
        hit_o.operand = 1'b0;
        if (enable_i && armed_i && idle_i && qualified && equal) begin // [RULE_01]
            hit_o.opcode  = bus_i.opcode_fetch;
            hit_o.operand = ~bus_i.opcode_fetch;
        end
    end

endmodule

/* rtl/abu_top.sv */
// What this block does
// [RULE_01] Enabled address match raises a breakpoint request
// [RULE_02] Force software interrupt opcode, pick break vector
// [RULE_03] Writing one to active bit triggers break
// [RULE_04] Return from interrupt ends break state
// [RULE_05] Opcode address hit breaks before execution
// [RULE_06] Operand address hit breaks after instruction
// [RULE_07] Software break taken before next instruction
// [RULE_08] Hit sets active bit; zero write, reset clear
// [RULE_09] Unchanged address gives no second break
// [RULE_10] Enable bit seven gates full address match
// [RULE_11] Two byte address registers, reset to zero
// [RULE_12] Flag clearing in break needs clear enable
// [RULE_13] Timer counter halted while break active
// [RULE_14] Watchdog off in break with test voltage
// [RULE_15] Flag records wait exit caused by break; code sets it only in emulation mode
// [RULE_16] Unit stays enabled in wait and stop
// [RULE_17] Handler reloads address, clears active bit
// [RULE_18] Only CPU program addresses may match
`include "abu_consts.svh"

module abu_top
    import abu_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input  wire logic              ref_clk_i,
    input  wire logic              srst_i,
    // APB slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [11:0]       paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // CPU and system integration side
    input  wire abu_cpu_bus_t      cpu_bus_i,
    input  wire logic              instr_start_i,
    input  wire logic              rti_exec_i,
    input  wire logic              monitor_mode_i,
    input  wire logic              wait_mode_i,
    input  wire logic              emulation_mode_i,
    input  wire logic              high_test_voltage_i,
    output logic                   breakpoint_request_o,
    output logic                   force_swi_o,
    output logic [7:0]             swi_opcode_o,
    output logic [ADDR_W-1:0]      vector_addr_o,
    output logic                   break_state_o,
    output logic                   timer_halt_o,
    output logic                   watchdog_disable_o,
    output logic                   flag_clear_allow_o,
    output logic                   irq_o
);

    function automatic logic sel(input logic [11:0] a, input logic [11:0] ofs);
        sel = (a == ofs);
    endfunction

    abu_state_t              state;
    abu_state_t              next_state;
    abu_hit_t                hit;
    logic                    break_enable_bit;
    logic                    break_active;
    logic                    armed;
    logic [7:0]              break_address_high;
    logic [7:0]              break_address_low;
    logic                    wait_exit_by_break;
    logic                    break_clear_enable;
    logic [`ABU_NUM_EV-1:0]  int_status;
    logic [`ABU_NUM_EV-1:0]  int_mask;
    logic [`ABU_NUM_EV-1:0]  events;
    logic                    tst_meta;
    logic                    tst_sync;
    logic                    next_take;
    logic                    apb_wr;
    logic                    apb_rd;
    logic                    wr_ctrl;
    logic                    sw_break;
    logic                    mapped;
    logic [7:0]              rd_byte;

    // APB: one wait state, registers commit on the pready edge
    assign apb_wr  = psel_i & penable_i & pready_o & pwrite_i;
    assign apb_rd  = psel_i & penable_i & ~pready_o & ~pwrite_i;
    assign wr_ctrl = apb_wr & sel(paddr_i, `ABU_OFS_CTRL);
    assign mapped  = sel(paddr_i, `ABU_OFS_CTRL) | sel(paddr_i, `ABU_OFS_ADDR_HIGH)
                   | sel(paddr_i, `ABU_OFS_ADDR_LOW) | sel(paddr_i, `ABU_OFS_WAIT_STAT)
                   | sel(paddr_i, `ABU_OFS_FLAG_CLR) | sel(paddr_i, `ABU_OFS_INT_STAT)
                   | sel(paddr_i, `ABU_OFS_INT_MASK);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
        end
    end

    always_comb begin
        rd_byte = `ABU_RST_BYTE;
        case (1'b1)
            sel(paddr_i, `ABU_OFS_CTRL): begin
                rd_byte[`ABU_BIT_ENABLE] = break_enable_bit;
                rd_byte[`ABU_BIT_ACTIVE] = break_active;
            end
            sel(paddr_i, `ABU_OFS_ADDR_HIGH): rd_byte = break_address_high;
            sel(paddr_i, `ABU_OFS_ADDR_LOW):  rd_byte = break_address_low;
            sel(paddr_i, `ABU_OFS_WAIT_STAT): rd_byte[`ABU_BIT_WAIT_EXIT] = wait_exit_by_break;
            sel(paddr_i, `ABU_OFS_FLAG_CLR):  rd_byte[`ABU_BIT_CLR_ENABLE] = break_clear_enable;
            sel(paddr_i, `ABU_OFS_INT_STAT):  rd_byte[`ABU_NUM_EV-1:0] = int_status;
            sel(paddr_i, `ABU_OFS_INT_MASK):  rd_byte[`ABU_NUM_EV-1:0] = int_mask;
            default:                          rd_byte = `ABU_RST_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            prdata_o <= 32'h00000000;
        end else if (apb_rd) begin
            prdata_o <= {24'h000000, rd_byte};
        end
    end

    // Enable bit
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            break_enable_bit <= 1'b0; // [RULE_10]
        end else if (wr_ctrl) begin
            break_enable_bit <= pwdata_i[`ABU_BIT_ENABLE]; // [RULE_10]
        end
    end

    // Breakpoint address registers
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            break_address_high <= `ABU_RST_BYTE; // [RULE_11]
            break_address_low  <= `ABU_RST_BYTE; // [RULE_11]
        end else begin
            if (apb_wr && sel(paddr_i, `ABU_OFS_ADDR_HIGH)) begin
                break_address_high <= pwdata_i[7:0];
            end
            if (apb_wr && sel(paddr_i, `ABU_OFS_ADDR_LOW)) begin
                break_address_low <= pwdata_i[7:0];
            end
        end
    end

    // A hit disarms; only reset or a write to either address register re-arms the comparator
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            armed <= 1'b1;
        end else if (apb_wr && (sel(paddr_i, `ABU_OFS_ADDR_HIGH)
                                || sel(paddr_i, `ABU_OFS_ADDR_LOW))) begin
            armed <= 1'b1;
        end else if (hit.opcode || hit.operand) begin
            armed <= 1'b0; // [RULE_09]
        end
    end

    abu_addr_match #(
        .ADDR_W (ADDR_W)
    ) u_match (
        .enable_i    (break_enable_bit),
        .armed_i     (armed),
        .idle_i      ((state == ABU_IDLE) && !break_active),
        .breakpoint_request_addr_i ({break_address_high, break_address_low}),
        .bus_i       (cpu_bus_i),
        .hit_o       (hit)
    );

    // Active bit: hit or software sets, zero write clears, set wins
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            break_active <= 1'b0; // [RULE_08]
        end else if (hit.opcode || hit.operand) begin
            break_active <= 1'b1; // [RULE_08]
        end else if (wr_ctrl) begin
            break_active <= pwdata_i[`ABU_BIT_ACTIVE]; // [RULE_03]
        end
    end

    assign sw_break = wr_ctrl & pwdata_i[`ABU_BIT_ACTIVE]; // [RULE_03]

    always_comb begin
        next_state = state;
        next_take  = 1'b0;
        case (state)
            ABU_IDLE: begin
                if (hit.opcode) begin
                    next_state = ABU_BRK; // [RULE_05]
                    next_take  = 1'b1;
                end else if (hit.operand || sw_break) begin
                    next_state = ABU_PEND; // [RULE_06]
                end
            end
            ABU_PEND: begin
                if (instr_start_i) begin
                    next_state = ABU_BRK; // [RULE_07]
                    next_take  = 1'b1;
                end
            end
            ABU_BRK: begin
                if (rti_exec_i) begin
                    next_state = ABU_IDLE; // [RULE_04]
                end
            end
            default: next_state = ABU_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state <= ABU_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Requests and forced opcode toward the system integration logic
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            breakpoint_request_o <= 1'b0;
            force_swi_o          <= 1'b0;
            swi_opcode_o         <= `ABU_SWI_OPCODE;
            vector_addr_o        <= `ABU_VEC_NORMAL;
            break_state_o        <= 1'b0;
        end else begin
            breakpoint_request_o <= next_take || (next_state == ABU_PEND); // [RULE_01]
            force_swi_o          <= next_take; // [RULE_02]
            swi_opcode_o         <= `ABU_SWI_OPCODE;
            if (next_take) begin
                vector_addr_o <= monitor_mode_i ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL; // [RULE_02]
            end
            break_state_o <= (next_state == ABU_BRK);
        end
    end

    // Test voltage level arrives from a pin
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tst_meta <= 1'b0;
            tst_sync <= 1'b0;
        end else begin
            tst_meta <= high_test_voltage_i;
            tst_sync <= tst_meta;
        end
    end

    // Side effects of the break state
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            timer_halt_o       <= 1'b0;
            watchdog_disable_o <= 1'b0;
            flag_clear_allow_o <= 1'b1;
        end else begin
            timer_halt_o       <= (next_state == ABU_BRK); // [RULE_13]
            watchdog_disable_o <= (next_state == ABU_BRK) && tst_sync; // [RULE_14]
            flag_clear_allow_o <= (next_state != ABU_BRK) || break_clear_enable; // [RULE_12]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            break_clear_enable <= 1'b0;
        end else if (apb_wr && sel(paddr_i, `ABU_OFS_FLAG_CLR)) begin
            break_clear_enable <= pwdata_i[`ABU_BIT_CLR_ENABLE]; // [RULE_12]
        end
    end

    // Wait exit flag: break while waiting, emulation only; zero write clears
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wait_exit_by_break <= 1'b0;
        end else if (next_take && wait_mode_i && emulation_mode_i) begin
            wait_exit_by_break <= 1'b1; // [RULE_15]
        end else if (apb_wr && sel(paddr_i, `ABU_OFS_WAIT_STAT)
                     && !pwdata_i[`ABU_BIT_WAIT_EXIT]) begin
            wait_exit_by_break <= 1'b0; // [RULE_15]
        end
    end

    // Interrupt status, write one to clear, set wins
    assign events[`ABU_EV_TAKEN]     = next_take;
    assign events[`ABU_EV_ENDED]     = (state == ABU_BRK) && rti_exec_i;
    assign events[`ABU_EV_WAIT_EXIT] = next_take && wait_mode_i && emulation_mode_i;

    genvar gi;
    generate
        for (gi = 0; gi < `ABU_NUM_EV; gi++) begin : g_ev
            always_ff @(posedge ref_clk_i) begin
                if (srst_i) begin
                    int_status[gi] <= 1'b0;
                end else if (events[gi]) begin
                    int_status[gi] <= 1'b1;
                end else if (apb_wr && sel(paddr_i, `ABU_OFS_INT_STAT) && pwdata_i[gi]) begin
                    int_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            int_mask <= `ABU_RST_EV;
        end else if (apb_wr && sel(paddr_i, `ABU_OFS_INT_MASK)) begin
            int_mask <= pwdata_i[`ABU_NUM_EV-1:0];
        end
    end

    function automatic logic [`ABU_NUM_EV-1:0] next_irq_status();
        logic [`ABU_NUM_EV-1:0] clr;
        clr = (apb_wr && sel(paddr_i, `ABU_OFS_INT_STAT)) ? pwdata_i[`ABU_NUM_EV-1:0]
                                                          : `ABU_RST_EV;
        next_irq_status = events | (int_status & ~clr);
    endfunction

    // Mask bit one lets its event reach the interrupt line
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(next_irq_status() & int_mask);
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    property p_hit_req;
        hit.opcode |=> breakpoint_request_o && force_swi_o;
    endproperty
    a_hit_req: assert property (p_hit_req) else $error("opcode hit gave no request"); // [RULE_01]

    property p_vector;
        force_swi_o |-> vector_addr_o == ($past(monitor_mode_i) ? `ABU_VEC_MONITOR
                                                                : `ABU_VEC_NORMAL);
    endproperty
    a_vector: assert property (p_vector) else $error("wrong break vector"); // [RULE_02]

    property p_sw_break;
        (state == ABU_IDLE) && sw_break && !hit.opcode |=> state == ABU_PEND;
    endproperty
    a_sw_break: assert property (p_sw_break) else $error("software break not pended"); // [RULE_03]

    property p_rti_end;
        (state == ABU_BRK) && rti_exec_i |=> state == ABU_IDLE ##1 !timer_halt_o;
    endproperty
    a_rti_end: assert property (p_rti_end) else $error("return did not end break"); // [RULE_04]

    property p_operand_wait;
        hit.operand |=> !force_swi_o && breakpoint_request_o;
    endproperty
    a_operand_wait: assert property (p_operand_wait) else $error("operand hit broke early"); // [RULE_06]

    property p_pend_take;
        (state == ABU_PEND) && instr_start_i |=> force_swi_o ##1 !force_swi_o;
    endproperty
    a_pend_take: assert property (p_pend_take) else $error("pending break not taken"); // [RULE_07]

    property p_active_set;
        hit.opcode || hit.operand |=> break_active && !armed;
    endproperty
    a_active_set: assert property (p_active_set) else $error("hit left flags wrong"); // [RULE_08]

    property p_enable_gate;
        !break_enable_bit |-> !hit.opcode && !hit.operand;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("hit while disabled"); // [RULE_10]

    property p_timer_halt;
        state == ABU_BRK |-> timer_halt_o;
    endproperty
    a_timer_halt: assert property (p_timer_halt) else $error("timer runs during break"); // [RULE_13]

    property p_flag_clear;
        (state == ABU_BRK) && $past(state == ABU_BRK) && !$past(break_clear_enable)
            |-> !flag_clear_allow_o;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag clear allowed in break"); // [RULE_12]

endmodule

/* testbench/abu_cpu_model.sv */
module abu_cpu_model
    import abu_pkg::*;
(
    input  wire logic    clk_i,
    input  wire logic    wait_mode_i,
    input  wire logic    force_swi_i,
    output abu_cpu_bus_t bus_o,
    output logic         instr_start_o,
    output logic         rti_exec_o,
    output logic [31:0]  swi_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_o = '0;
        instr_start_o = 1'h0;
        rti_exec_o = 1'h0;
        swi_cnt_o = 32'h0;
    end

    // Counts opcodes forced into the core
    always @(posedge clk_i) begin
        if (force_swi_i === 1'h1) begin
            swi_cnt_o <= swi_cnt_o + 32'h1;
        end
    end

    // Cycle is driven with valid low in wait mode; released bus shows valid low and the other fields inverted
    task automatic cycle(input logic [15:0] a, input logic fc, input logic op);
        bus_o <= '{addr: a, valid: !wait_mode_i, from_cpu: fc, opcode_fetch: op};
        @(posedge clk_i);
        bus_o <= '{addr: ~a, valid: 1'h0, from_cpu: ~fc, opcode_fetch: ~op};
    endtask

    task automatic boundary();
        instr_start_o <= 1'h1;
        @(posedge clk_i);
        instr_start_o <= 1'h0;
    endtask

    task automatic return_from_interrupt_opcode();
        rti_exec_o <= 1'h1;
        @(posedge clk_i);
        rti_exec_o <= 1'h0;
    endtask
endmodule

/* testbench/testbench.sv */
`include "abu_consts.svh"

module testbench
    import abu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk;
    logic         srst;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [11:0]  paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    abu_cpu_bus_t cpu_bus;
    logic         instr_start;
    logic         rti_exec;
    logic         mon_mode;
    logic         wait_mode;
    logic         emu_mode;
    logic         htv;
    logic         breakpoint_request_req;
    logic         force_swi;
    logic [7:0]   swi_op;
    logic [15:0]  vec_addr;
    logic         brk_state;
    logic         tmr_halt;
    logic         wdog_dis;
    logic         clr_allow;
    logic         irq;
    logic [31:0]  swi_cnt;
    int           error_cnt;
    int           checks_done;
    int           cyc = 0;
    logic [31:0]  seed;
    logic [31:0]  r;
    logic [15:0]  a;
    logic [7:0]   q;
    logic         e;
    logic [11:0]  ofs [7] = '{`ABU_OFS_CTRL, `ABU_OFS_ADDR_HIGH, `ABU_OFS_ADDR_LOW,
        `ABU_OFS_WAIT_STAT, `ABU_OFS_FLAG_CLR, `ABU_OFS_INT_STAT, `ABU_OFS_INT_MASK};

    abu_top abu_top_i (
        .ref_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .cpu_bus_i(cpu_bus),
        .instr_start_i(instr_start), .rti_exec_i(rti_exec), .monitor_mode_i(mon_mode),
        .wait_mode_i(wait_mode), .emulation_mode_i(emu_mode), .high_test_voltage_i(htv),
        .breakpoint_request_o(breakpoint_request_req), .force_swi_o(force_swi), .swi_opcode_o(swi_op),
        .vector_addr_o(vec_addr), .break_state_o(brk_state), .timer_halt_o(tmr_halt),
        .watchdog_disable_o(wdog_dis), .flag_clear_allow_o(clr_allow), .irq_o(irq)
    );

    abu_cpu_model abu_cpu_model_i (
        .clk_i(clk), .wait_mode_i(wait_mode), .force_swi_i(force_swi), .bus_o(cpu_bus),
        .instr_start_o(instr_start), .rti_exec_o(rti_exec), .swi_cnt_o(swi_cnt)
    );

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] vec(input logic m);
        return m ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] ad, input logic [7:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        // Only the bench timeout ends a hang here
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] ad, input logic [7:0] exp, input string nm);
        apb(1'h0, ad, 8'h00);
        chk(nm, {e, q}, {1'h0, exp});
    endtask

    task automatic end_test(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {mon_mode, wait_mode, emu_mode, htv} = '0;
        {error_cnt, checks_done} = '0;
        seed = 32'h1DD1;
        srst = 1'h1;
        repeat (8) @(posedge clk);
        srst <= 1'h0;
        for (int i = 0; i < 7; i++) rd(ofs[i], 8'h00, "reset value");
        apb(1'h0, 12'h01C, 8'h5A);
        chk("unmapped", {e, q}, 9'h100);
        end_test("reset");
        for (int i = 0; i < 6; i++) begin
            r = xs();
            a = r[15:0];
            mon_mode <= r[16];
            apb(1'h1, `ABU_OFS_ADDR_HIGH, a[15:8]);
            apb(1'h1, `ABU_OFS_ADDR_LOW, a[7:0]);
            apb(1'h1, `ABU_OFS_CTRL, 8'h80);
            abu_cpu_model_i.cycle(a, 1'h0, 1'h1);
            abu_cpu_model_i.cycle(a ^ (16'h0001 << r[23:20]), 1'h1, 1'h1);
            wait_mode <= 1'h1;
            @(posedge clk);
            abu_cpu_model_i.cycle(a, 1'h1, 1'h1);
            wait_mode <= 1'h0;
            @(posedge clk);
            chk("no request", breakpoint_request_req, 1'h0);
            abu_cpu_model_i.cycle(a, 1'h1, r[24]);
            @(posedge clk);
            chk("request", breakpoint_request_req, 1'h1);
            chk("swi forced", force_swi, r[24]);
            if (!r[24]) begin
                repeat (2) @(posedge clk);
                chk("swi held", force_swi, 1'h0);
                abu_cpu_model_i.boundary();
                @(posedge clk);
                chk("swi late", force_swi, 1'h1);
            end
            chk("vector", vec_addr, vec(r[16]));
            chk("opcode", swi_op, `ABU_SWI_OPCODE);
            chk("timer halt", tmr_halt, 1'h1);
            @(posedge clk);
            chk("swi pulse", force_swi, 1'h0);
            rd(`ABU_OFS_CTRL, 8'hC0, "active set");
            apb(1'h1, `ABU_OFS_CTRL, 8'h80);
            abu_cpu_model_i.return_from_interrupt_opcode();
            @(posedge clk);
            chk("break ended", brk_state, 1'h0);
            end_test("address hit");
        end
        abu_cpu_model_i.cycle(a, 1'h1, 1'h1);
        repeat (3) @(posedge clk);
        chk("no rebreak", breakpoint_request_req, 1'h0);
        chk("swi count", swi_cnt, 32'h6);
        end_test("no rearm");
        {wait_mode, emu_mode, htv} <= 3'h7;
        apb(1'h1, `ABU_OFS_CTRL, 8'h40);
        @(posedge clk);
        chk("sw request", breakpoint_request_req, 1'h1);
        chk("sw waits", force_swi, 1'h0);
        abu_cpu_model_i.boundary();
        @(posedge clk);
        chk("sw taken", force_swi, 1'h1);
        repeat (5) @(posedge clk);
        chk("watchdog off", wdog_dis, 1'h1);
        chk("no clearing", clr_allow, 1'h0);
        rd(`ABU_OFS_WAIT_STAT, 8'h02, "wait exit");
        apb(1'h1, `ABU_OFS_FLAG_CLR, 8'h80);
        @(posedge clk);
        chk("clearing", clr_allow, 1'h1);
        htv <= 1'h0;
        repeat (5) @(posedge clk);
        chk("watchdog on", wdog_dis, 1'h0);
        apb(1'h1, `ABU_OFS_WAIT_STAT, 8'h00);
        rd(`ABU_OFS_WAIT_STAT, 8'h00, "wait exit clear");
        // All events pending but none let through yet
        chk("irq masked", irq, 1'h0);
        rd(`ABU_OFS_INT_STAT, 8'h07, "events");
        apb(1'h1, `ABU_OFS_INT_MASK, 8'h07);
        @(posedge clk);
        chk("irq", irq, 1'h1);
        apb(1'h1, `ABU_OFS_INT_STAT, 8'h07);
        rd(`ABU_OFS_INT_STAT, 8'h00, "events cleared");
        chk("irq cleared", irq, 1'h0);
        apb(1'h1, `ABU_OFS_INT_MASK, 8'h00);
        rd(`ABU_OFS_CTRL, 8'h40, "sw active");
        apb(1'h1, `ABU_OFS_CTRL, 8'h00);
        rd(`ABU_OFS_CTRL, 8'h00, "active cleared");
        wait_mode <= 1'h0;
        abu_cpu_model_i.return_from_interrupt_opcode();
        @(posedge clk);
        chk("sw break ended", brk_state, 1'h0);
        end_test("software break");
        complete_run();
    end
endmodule
